// File: src/mpm_pkg.sv
/*
  Constants and carrier types for the memory page mapper.
  Assumes one synchronous clock domain and an 8-bit I/O port space.
*/
package mpm_pkg;

  // ----------------------------------------------------------------
  // address geometry
  // ----------------------------------------------------------------
  localparam int CPU_AW    = 16;  // processor address width
  localparam int PHYS_AW   = 20;  // system address width (1 Mbyte)
  localparam int PAGE_BITS = 12;  // 4 Kbyte page offset
  localparam int IDX_BITS  = 4;   // page index width
  localparam int ENTRIES   = 16;  // one table entry per page
  localparam int ENTRY_W   = 8;   // stored entry width
  localparam int EXT_BITS  = PHYS_AW - CPU_AW;

  localparam logic [EXT_BITS-1:0] EXT_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // I/O port map (low and high base jumper settings)
  // ----------------------------------------------------------------
  localparam logic [7:0] IO_BASE_LO  = 8'h00;
  localparam logic [7:0] IO_BASE_HI  = 8'h10;
  localparam logic [7:0] TBL_BASE_LO = 8'h20;
  localparam logic [7:0] TBL_BASE_HI = 8'h30;
  localparam logic [7:0] ON_OFFSET   = 8'h0a;  // mapper_on_port
  localparam logic [7:0] OFF_OFFSET  = 8'h0b;  // translation off port

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;    // one-cycle I/O write strobe
    logic       rd;    // one-cycle I/O read strobe
    logic [7:0] addr;  // I/O port number
    logic [7:0] data;  // write data
  } mpm_io_req_t;

  typedef enum logic [1:0] {
    MPM_OFF = 2'b01,
    MPM_ON  = 2'b10
  } mpm_state_t;

endpackage

// File: src/mpm_page_mapper.sv
/*
  Memory page mapper: widens a 64K processor address to a 1 Mbyte
  system address through a 16-entry page table loaded by I/O writes.
  Assumes I/O strobes and the processor address are synchronous to clk
  and that each strobe lasts one cycle per bus access.
*/
// Overview of operation
// - reset forces mapper off, full 64K untranslated.
// - write to base+0A turns translation on, data ignored.
// - read from base+0B turns translation off at any time.
// - translation off: address passes through, extended bits zero.
// - 16 write-only entry ports from 20h or 30h per jumper.
// - entries may be rewritten while translation is on.
// - each entry relocates a 4 Kbyte page within 1 Mbyte.
// - inverted FF..F0 gives identity map, extended bits zero.
`timescale 1ns/1ps

module mpm_page_mapper
  import mpm_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // base jumper: low selects 00h/20h, high selects 10h/30h
  input  wire logic               base_sel,
  // processor I/O cycles
  input  wire mpm_io_req_t        io_req,
  // processor memory address
  input  wire logic [CPU_AW-1:0]  cpu_addr,
  // translated system address and mapper status
  output logic      [PHYS_AW-1:0] phys_addr,
  output logic                    mapper_on
);

  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic [7:0]          io_base;
  logic [7:0]          tbl_base;
  logic                on_hit;
  logic                off_hit;
  logic                tbl_hit;
  logic [IDX_BITS-1:0] wr_idx;
  logic [7:0]          alt_io_base;
  logic [7:0]          alt_tbl_base;

  // jumper picks both port groups together
  assign io_base  = base_sel ? IO_BASE_HI : IO_BASE_LO;
  assign tbl_base = base_sel ? TBL_BASE_HI : TBL_BASE_LO;
  assign on_hit   = io_req.wr && (io_req.addr == io_base + ON_OFFSET);
  assign off_hit  = io_req.rd && (io_req.addr == io_base + OFF_OFFSET);
  // upper nibble of the port selects the table window of 16 ports
  assign tbl_hit  = io_req.wr &&
                    (io_req.addr[7:IDX_BITS] == tbl_base[7:IDX_BITS]);
  assign wr_idx   = io_req.addr[IDX_BITS-1:0];

  // ports of the other jumper setting; only the checks read them, to
  // show that a misplaced access really is ignored
  assign alt_io_base  = base_sel ? IO_BASE_LO : IO_BASE_HI;
  assign alt_tbl_base = base_sel ? TBL_BASE_LO : TBL_BASE_HI;

  // ----------------------------------------------------------------
  // enable state
  // ----------------------------------------------------------------
  mpm_state_t state;

  // off wins over on so that switching off always works; software may
  // read the off port in any state, even with the table half loaded
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= MPM_OFF;
      mapper_on <= 1'b0;
    end
    else if (off_hit)
    begin
      state     <= MPM_OFF;
      mapper_on <= 1'b0;
    end
    else if (on_hit)
    begin
      state     <= MPM_ON;
      mapper_on <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // page table
  // ----------------------------------------------------------------
  // no reset: contents are undefined until software loads them, like
  // the original RAM; writes are accepted in either state
  logic [ENTRY_W-1:0] page_tbl [ENTRIES];

  for (genvar i = 0; i < ENTRIES; i++)
  begin : g_entry
    always_ff @(posedge clk)
    begin
      if (tbl_hit && wr_idx == IDX_BITS'(i))
      begin
        page_tbl[i] <= io_req.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // address translation
  // ----------------------------------------------------------------
  logic [ENTRY_W-1:0] lookup;
  logic [PHYS_AW-1:0] next_phys_addr;

  assign lookup = page_tbl[cpu_addr[CPU_AW-1:PAGE_BITS]];

  // stored value is the complement of the page number
  always_comb
  begin
    if (state == MPM_ON)
    begin
      next_phys_addr = {~lookup, cpu_addr[PAGE_BITS-1:0]};
    end
    else
    begin
      next_phys_addr = {EXT_ZERO, cpu_addr};
    end
  end

  // registered so the output comes from a flop; one cycle of latency
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phys_addr <= '0;
    end
    else
    begin
      phys_addr <= next_phys_addr;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic rst_q;

  // delayed reset: the reset edge lowers rst before the checks start
  // their attempts, so the cycle right after a reset is skipped too
  always_ff @(posedge clk)
  begin
    rst_q <= rst;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rst_q);

  a_reset_off: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> (state == MPM_OFF) && !mapper_on)
    else $error("mapper not off after reset");

  a_enable_port: assert property (
    on_hit && !off_hit |=> state == MPM_ON && mapper_on)
    else $error("enable port did not turn mapper on");

  a_disable_port: assert property (
    off_hit |=> state == MPM_OFF && !mapper_on)
    else $error("disable port did not turn mapper off");

  a_state_hold: assert property (
    !on_hit && !off_hit |=> $stable(state))
    else $error("mapper state changed without a strobe");

  a_jumper_on: assert property (
    io_req.wr && io_req.addr == alt_io_base + ON_OFFSET && !mapper_on
    |=> !mapper_on)
    else $error("enable port of the other base was obeyed");

  a_jumper_off: assert property (
    io_req.rd && io_req.addr == alt_io_base + OFF_OFFSET && mapper_on
    |=> mapper_on)
    else $error("disable port of the other base was obeyed");

  a_passthrough: assert property (
    state == MPM_OFF |=> phys_addr == {EXT_ZERO, $past(cpu_addr)})
    else $error("address altered while mapper off");

  a_table_write: assert property (
    tbl_hit |=> page_tbl[$past(wr_idx)] == $past(io_req.data))
    else $error("table entry not stored");

  // a loaded table is only guaranteed once translation is on, so the
  // window check waits for that to avoid comparing unknown entries
  a_jumper_tbl: assert property (
    mapper_on && io_req.wr &&
    io_req.addr[7:IDX_BITS] == alt_tbl_base[7:IDX_BITS]
    |=> page_tbl[$past(wr_idx)] == $past(page_tbl[wr_idx]))
    else $error("table window of the other base was written");

  a_page_offset: assert property (
    1'b1 |=> phys_addr[PAGE_BITS-1:0] == $past(cpu_addr[PAGE_BITS-1:0]))
    else $error("page offset bits altered");

  a_page_map: assert property (
    state == MPM_ON |=>
      phys_addr[PHYS_AW-1:PAGE_BITS] == ~$past(lookup) &&
      phys_addr[PAGE_BITS-1:0] == $past(cpu_addr[PAGE_BITS-1:0]))
    else $error("translated address wrong");

  a_identity_map: assert property (
    state == MPM_ON &&
    lookup == ~{EXT_ZERO, cpu_addr[CPU_AW-1:PAGE_BITS]} |=>
      phys_addr == {EXT_ZERO, $past(cpu_addr)})
    else $error("identity pattern did not map low 64K");

  // main scenarios: switch on, bank change while on, switch off, the
  // high jumper setting and the identity table
  c_enable: cover property (state == MPM_OFF ##1 state == MPM_ON);
  c_rewrite_on: cover property (state == MPM_ON && tbl_hit);
  c_disable_on: cover property (state == MPM_ON ##1 state == MPM_OFF);
  c_jumper_high: cover property (base_sel && on_hit);
  c_identity: cover property (
    state == MPM_ON &&
    lookup == ~{EXT_ZERO, cpu_addr[CPU_AW-1:PAGE_BITS]});

endmodule

// File: sim/mpm_cpu_model.sv
/* processor-side model: one-cycle I/O port cycles to the mapper.
   assumes a free-running clk shared with the mapper. */
`timescale 1ns/1ps
module mpm_cpu_model
  import mpm_pkg::*;
(
  // clock
  input  wire logic  clk,
  // I/O cycles toward the mapper
  output mpm_io_req_t io_req
);
  initial io_req = '0;
  // one strobe cycle, then idle; wr high writes, else reads
  task automatic io_cyc(input logic w, input logic [7:0] a, d);
    @(posedge clk) io_req <= '{wr: w, rd: ~w, addr: a, data: d};
    @(posedge clk) io_req <= '0;
  endtask
  // table ram holds complements, so pages go out inverted
  task automatic put_page(input logic [7:0] port, page);
    io_cyc(1'b1, port, ~page);
  endtask
  // whole table first, since ram powers up random; then enable
  task automatic init_map(input logic [7:0] tbl, on_port);
    for (int i = 0; i < ENTRIES; i++)
      put_page(tbl + i[7:0], i[7:0]);
    io_cyc(1'b1, on_port, 8'h00);
  endtask
endmodule

// File: sim/mpm_page_mapper_tb.sv
/* self-checking bench for the memory page mapper.
   assumes the processor model drives all I/O cycles. */
`timescale 1ns/1ps
module mpm_page_mapper_tb
  import mpm_pkg::*;
;
  logic              clk;
  logic              rst;
  logic              base_sel;
  logic [15:0]       cpu_addr;
  logic [19:0]       phys_addr;
  logic              mapper_on;
  mpm_io_req_t       io_req;
  int                err_total = 0;
  int                tests_run = 0;

  mpm_page_mapper dut_u (.clk(clk), .rst(rst), .base_sel(base_sel),
    .io_req(io_req), .cpu_addr(cpu_addr), .phys_addr(phys_addr),
    .mapper_on(mapper_on));
  mpm_cpu_model cpu_u (.clk(clk), .io_req(io_req));

  always #4 clk = ~clk;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [19:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // registered output: two edges before looking
  task automatic xlate(input logic [15:0] a, input logic [19:0] e);
    @(posedge clk) cpu_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk("phys_addr", e, phys_addr);
  endtask
  task automatic on_is(input logic e);
    #1 chk("mapper_on", {19'h0, e}, {19'h0, mapper_on});
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // run needs under a hundred cycles; this is ample margin
  initial
  begin
    #20000 err_total++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    clk = 0; rst = 1; base_sel = 0; cpu_addr = 16'h0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    xlate(16'hf123, 20'h0f123);
    on_is(1'b0);
    cpu_u.init_map(TBL_BASE_LO, IO_BASE_LO + ON_OFFSET);
    on_is(1'b1);
    xlate(16'h5abc, 20'h05abc);
    cpu_u.put_page(TBL_BASE_LO + 8'h03, 8'hc7);
    xlate(16'h3123, 20'hc7123);
    xlate(16'h4fff, 20'h04fff);
    cpu_u.io_cyc(1'b0, IO_BASE_LO + OFF_OFFSET, 8'h00);
    on_is(1'b0);
    xlate(16'h3123, 20'h03123);
    // high jumper: low ports must then be ignored
    @(posedge clk) base_sel <= 1'b1;
    cpu_u.io_cyc(1'b1, IO_BASE_LO + ON_OFFSET, 8'h00);
    on_is(1'b0);
    cpu_u.put_page(TBL_BASE_HI + 8'h0f, 8'hab);
    cpu_u.io_cyc(1'b1, IO_BASE_HI + ON_OFFSET, 8'h5a);
    on_is(1'b1);
    cpu_u.put_page(TBL_BASE_LO + 8'h0f, 8'h11);
    xlate(16'hf001, 20'hab001);
    cpu_u.io_cyc(1'b0, IO_BASE_LO + OFF_OFFSET, 8'h00);
    on_is(1'b1);
    cpu_u.io_cyc(1'b0, IO_BASE_HI + OFF_OFFSET, 8'h00);
    on_is(1'b0);
    cpu_u.io_cyc(1'b1, IO_BASE_HI + ON_OFFSET, 8'h00);
    on_is(1'b1);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    on_is(1'b0);
    xlate(16'hf001, 20'h0f001);
    tally_and_finish;
  end
endmodule
